/* hw/sccs_top.sv */
/*
 * Clock-source control: oscillator start/stop, glitch-free main clock
 * selection with status, CPU clock divider and peripheral clock enables.
 * Assumes oscillator outputs arrive as one-cycle ticks synchronous to
 * ref_clk and the CPU reaches registers by byte reads and writes.
 */
`timescale 1ns/10ps
`default_nettype none
`include "sccs_map.svh"

module sccs_top
    import sccs_pkg::*;
(
    input  wire logic           ref_clk,
    input  wire logic           reset,
    input  wire logic [15:0]    reg_addr,
    input  wire logic [7:0]     reg_wdata,
    input  wire logic           reg_wr,
    input  wire logic           reg_rd,
    output logic      [7:0]     reg_rdata,
    input  wire logic           opt_hs_is_x1,
    input  wire logic           opt_ls_stoppable,
    input  wire logic           stop_mode,
    input  wire sccs_osc_tick_t osc_tick,
    output sccs_osc_run_t       osc_run,
    output sccs_clk_out_t       clk_out
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    // Counter terminal value for a divide code
    function automatic logic [3:0] div_mask(input logic [2:0] code);
        div_mask = 4'((5'h01 << code) - 5'h01);
    endfunction

    // Legal codes depend on the source actually running
    function automatic logic div_legal(input logic [2:0] code, input logic hs);
        div_legal = hs ? (code <= `SCCS_DIV_MAX_HS) : (code <= `SCCS_DIV_MAX_LS);
    endfunction

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [2:0]     cpu_div_r;
    logic [2:0]     div_eff_r;
    logic [3:0]     div_cnt_r;
    logic           instr_ph_r;
    logic [6:0]     tmr8_cnt_r;
    logic           main_sel_r;
    logic           hs_stop_r;
    logic           ls_stop_r;
    logic           opt_loaded_r;
    logic           opt_hs_x1_r;
    logic           opt_ls_stop_ok_r;
    logic           mux_sel_r;
    sccs_sw_state_t sw_state_r;
    sccs_sw_state_t sw_state_nxt;
    logic [7:0]     rdata_r;
    logic [7:0]     rdata_nxt;

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    // Full address compare, so no register has an alias
    wire logic wr_div  = reg_wr && (reg_addr == `SCCS_CPU_DIV_OFS);
    wire logic wr_main = reg_wr && (reg_addr == `SCCS_MAIN_MODE_OFS);
    wire logic wr_hs   = reg_wr && (reg_addr == `SCCS_HS_CTRL_OFS);
    wire logic wr_ls   = reg_wr && (reg_addr == `SCCS_LS_MODE_OFS);

    // ------------------------------------------------------------
    // Write fields
    // ------------------------------------------------------------
    // Only the defined bits are kept, the rest of each byte is dropped
    wire logic [2:0] div_code_w = reg_wdata[`SCCS_DIV_FIELD_W-1:0];
    wire logic       main_sel_w = reg_wdata[`SCCS_MAIN_SEL_BIT];
    wire logic       hs_stop_w  = reg_wdata[`SCCS_HS_STOP_BIT];
    wire logic       ls_stop_w  = reg_wdata[`SCCS_LS_STOP_BIT];

    // ------------------------------------------------------------
    // Register read images
    // ------------------------------------------------------------
    // Spare bits read as zero whatever software wrote to them
    wire logic [7:0] div_image  = {5'h00, cpu_div_r};
    wire logic [7:0] main_image = {6'h00, mux_sel_r, main_sel_r};
    wire logic [7:0] hs_image   = {hs_stop_r, 7'h00};
    wire logic [7:0] ls_image   = {7'h00, ls_stop_r};

    // ------------------------------------------------------------
    // Oscillator run control
    // ------------------------------------------------------------
    // High-speed stopped by stop bit or stop instruction
    wire logic hs_run = !hs_stop_r && !stop_mode;
    // Option flop is low under reset, so the internal oscillator runs then
    assign osc_run.x1_run     = hs_run && opt_hs_x1_r;
    assign osc_run.hs_int_run = hs_run && !opt_hs_x1_r;
    // Running unless software stop is both written and permitted
    wire logic ls_run = !(ls_stop_r && opt_ls_stop_ok_r);
    assign osc_run.ls_run = ls_run;

    // Live ticks of each source, silenced when its oscillator is stopped
    wire logic hs_tick = hs_run && (opt_hs_x1_r ? osc_tick.x1 : osc_tick.hs_int);
    wire logic ls_tick = ls_run && osc_tick.ls;

    // ------------------------------------------------------------
    // Glitch-free main clock switch
    // ------------------------------------------------------------
    // Old source is let through to the end of its period, then the
    // output waits for the first edge of the new one before moving.
    wire logic old_tick  = mux_sel_r ? hs_tick : ls_tick;
    wire logic new_tick  = mux_sel_r ? ls_tick : hs_tick;
    wire logic old_dead  = mux_sel_r ? !hs_run : !ls_run;

    always_comb begin
        sw_state_nxt = sw_state_r;
        case (sw_state_r)
            SCCS_SW_IDLE: begin
                if (main_sel_r != mux_sel_r) begin
                    sw_state_nxt = SCCS_SW_DRAIN_OLD;
                end
            end
            SCCS_SW_DRAIN_OLD: begin
                if (old_tick || old_dead) begin
                    sw_state_nxt = SCCS_SW_WAIT_NEW;
                end
            end
            SCCS_SW_WAIT_NEW: begin
                if (new_tick) begin
                    sw_state_nxt = SCCS_SW_IDLE;
                end
            end
            default: begin
                sw_state_nxt = SCCS_SW_IDLE;
            end
        endcase
    end

    // A stopped new source holds the switch here and the CPU gets no ticks
    wire logic sw_waiting = (sw_state_r == SCCS_SW_WAIT_NEW);
    wire logic sw_commit  = sw_waiting && new_tick;

    // Old ticks pass while draining, nothing while waiting for new
    wire logic main_tick = sw_waiting ? 1'b0 : old_tick;

    // ------------------------------------------------------------
    // CPU divider and derived enables
    // ------------------------------------------------------------
    wire logic div_wrap = main_tick && (div_cnt_r == div_mask(div_eff_r));
    // Illegal code for the running source keeps the previous ratio
    wire logic div_take = div_legal(cpu_div_r, mux_sel_r);

    assign clk_out.main       = main_tick;
    assign clk_out.periph     = main_tick;
    assign clk_out.cpu        = div_wrap;
    assign clk_out.instr_slot = div_wrap && instr_ph_r;
    // Low-speed users stay clocked whatever the main selection
    assign clk_out.wdt        = ls_tick;
    assign clk_out.tmr8       = ls_tick && (&tmr8_cnt_r);

    // ------------------------------------------------------------
    // Register read
    // ------------------------------------------------------------
    always_comb begin
        rdata_nxt = rdata_r;
        if (reg_rd) begin
            case (reg_addr)
                `SCCS_CPU_DIV_OFS:   rdata_nxt = div_image;
                `SCCS_MAIN_MODE_OFS: rdata_nxt = main_image;
                `SCCS_HS_CTRL_OFS:   rdata_nxt = hs_image;
                `SCCS_LS_MODE_OFS:   rdata_nxt = ls_image;
                default:             rdata_nxt = 8'h00;
            endcase
        end
    end

    // Straight from the flop, never from the decode
    assign reg_rdata = rdata_r;

    // ------------------------------------------------------------
    // Option capture
    // ------------------------------------------------------------
    // Taken in the first clock after release, never under reset itself
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            opt_loaded_r     <= 1'b0;
            opt_hs_x1_r      <= 1'b0;
            opt_ls_stop_ok_r <= 1'b0;
        end else if (!opt_loaded_r) begin
            opt_loaded_r     <= 1'b1;
            opt_hs_x1_r      <= opt_hs_is_x1;
            opt_ls_stop_ok_r <= opt_ls_stoppable;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cpu_div_r  <= 3'h0;
            main_sel_r <= 1'b0;
            hs_stop_r  <= 1'b0;
            ls_stop_r  <= 1'b0;
        end else begin
            // Writes land at the strobe edge, with no wait states
            if (wr_div) begin
                cpu_div_r <= div_code_w;
            end
            if (wr_main) begin
                main_sel_r <= main_sel_w;
            end
            if (wr_hs) begin
                hs_stop_r <= hs_stop_w;
            end
            if (wr_ls) begin
                ls_stop_r <= ls_stop_w;
            end
        end
    end

    // ------------------------------------------------------------
    // Switch state
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sw_state_r <= SCCS_SW_IDLE;
            mux_sel_r  <= 1'b0;
        end else begin
            sw_state_r <= sw_state_nxt;
            if (sw_commit) begin
                mux_sel_r <= ~mux_sel_r;
            end
        end
    end

    // ------------------------------------------------------------
    // Divider counters
    // ------------------------------------------------------------
    // New ratio loads only on a wrap, so no CPU period is cut short
    // Restart on a commit keeps the first period on the new source whole
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            div_eff_r  <= 3'h0;
            div_cnt_r  <= 4'h0;
            instr_ph_r <= 1'b0;
        end else if (sw_commit) begin
            div_cnt_r <= 4'h0;
        end else if (div_wrap) begin
            div_cnt_r  <= 4'h0;
            instr_ph_r <= ~instr_ph_r;
            if (div_take) begin
                div_eff_r <= cpu_div_r;
            end
        end else if (main_tick) begin
            div_cnt_r <= div_cnt_r + 4'h1;
        end
    end

    // Free-running prescaler, its phase is not tied to any write
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            tmr8_cnt_r <= 7'h00;
        end else if (ls_tick) begin
            tmr8_cnt_r <= tmr8_cnt_r + 7'h01;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Last read is held so a slow master may sample late
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rdata_r <= `SCCS_REG_RESET;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

endmodule
`default_nettype wire

/* include/sccs_map.svh */
/*
 * Register offsets, field positions, reset values and timing figures of the
 * clock-source control block.
 * Assumes inclusion by bare name from the package and the design file.
 */
`ifndef SCCS_MAP_SVH
`define SCCS_MAP_SVH

// ------------------------------------------------------------
// Register offsets (CPU data space)
// ------------------------------------------------------------
`define SCCS_CPU_DIV_OFS        16'hfffb
`define SCCS_MAIN_MODE_OFS      16'hffa1
`define SCCS_HS_CTRL_OFS        16'hffa2
`define SCCS_LS_MODE_OFS        16'hffa0

// ------------------------------------------------------------
// Field positions, reset values and divide code limits
// ------------------------------------------------------------
`define SCCS_DIV_FIELD_W        3
`define SCCS_MAIN_SEL_BIT       0
`define SCCS_MAIN_STAT_BIT      1
`define SCCS_HS_STOP_BIT        7
`define SCCS_LS_STOP_BIT        0
`define SCCS_REG_RESET          8'h00
`define SCCS_DIV_MAX_HS         3'h4
`define SCCS_DIV_MAX_LS         3'h1

// ------------------------------------------------------------
// Timing figures
// ------------------------------------------------------------
`define SCCS_INSTR_MIN_CLKS     2
`define SCCS_TMR8_LS_DIV_LOG2   7

`endif

/* include/sccs_pkg.sv */
/*
 * Types of the clock-source control block.
 * Assumes sccs_map.svh is on the include path.
 */
`include "sccs_map.svh"

package sccs_pkg;

    // Oscillator ticks, one-cycle enables synchronous to ref_clk
    typedef struct packed {
        logic x1;
        logic hs_int;
        logic ls;
    } sccs_osc_tick_t;

    // Derived clock enables handed to the CPU and peripherals
    typedef struct packed {
        logic main;
        logic cpu;
        logic periph;
        logic instr_slot;
        logic wdt;
        logic tmr8;
    } sccs_clk_out_t;

    // Oscillator run requests to the analog circuits
    typedef struct packed {
        logic x1_run;
        logic hs_int_run;
        logic ls_run;
    } sccs_osc_run_t;

    typedef enum logic [1:0] {
        SCCS_SW_IDLE,
        SCCS_SW_DRAIN_OLD,
        SCCS_SW_WAIT_NEW
    } sccs_sw_state_t;

endpackage

/* tb/sccs_properties.sv */
/*
 * Port checks of the clock-source control block.
 * Assumes sccs_pkg is compiled first; bound to sccs_top below.
 */
`timescale 1ns/10ps
`default_nettype none

module sccs_properties
    import sccs_pkg::*;
(
    input wire logic           ref_clk,
    input wire logic           reset,
    input wire logic [15:0]    reg_addr,
    input wire logic [7:0]     reg_wdata,
    input wire logic           reg_wr,
    input wire logic           reg_rd,
    input wire logic [7:0]     reg_rdata,
    input wire logic           opt_hs_is_x1,
    input wire logic           opt_ls_stoppable,
    input wire logic           stop_mode,
    input wire sccs_osc_tick_t osc_tick,
    input wire sccs_osc_run_t  osc_run,
    input wire sccs_clk_out_t  clk_out
);
    // ------------------------------------------------------------
    // Sequences
    // ------------------------------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence ls_stop_wr;
        reg_wr && reg_addr == 16'hffa0 && reg_wdata[0];
    endsequence

    sequence hs_halted;
        !osc_run.x1_run && !osc_run.hs_int_run;
    endsequence

    // Cpu ticks since the last instruction slot, saturating
    logic [1:0] cpu_since_r;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            cpu_since_r <= 2'h0;
        end else if (clk_out.instr_slot) begin
            cpu_since_r <= 2'h0;
        end else if (clk_out.cpu && cpu_since_r != 2'h3) begin
            cpu_since_r <= cpu_since_r + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    reset_clear_a: assert property (disable iff (1'b0) reset |=> reg_rdata == 8'h00 && osc_run.ls_run)
        else $error("reset state wrong");
    ls_stop_a: assert property (ls_stop_wr ##0 opt_ls_stoppable |=> !osc_run.ls_run [*2])
        else $error("low-speed stop ignored");
    ls_locked_a: assert property (ls_stop_wr ##0 !opt_ls_stoppable |=> osc_run.ls_run)
        else $error("low-speed stopped while locked");
    hs_stop_a: assert property (reg_wr && reg_addr == 16'hffa2 && reg_wdata[7] |=> hs_halted)
        else $error("high-speed stop ignored");
    stop_instr_a: assert property (stop_mode |-> hs_halted)
        else $error("stop mode left oscillator running");
    x1_option_a: assert property (!opt_hs_is_x1 && !$past(reset) |-> !osc_run.x1_run)
        else $error("crystal runs while not chosen");
    periph_main_a: assert property (clk_out.periph == clk_out.main)
        else $error("peripheral tick differs from main");
    wdt_live_a: assert property (clk_out.wdt == (osc_tick.ls && osc_run.ls_run))
        else $error("watchdog tick differs from low-speed tick");
    instr_pair_a: assert property (clk_out.cpu |-> clk_out.instr_slot == (cpu_since_r == 2'h1))
        else $error("instruction slot not every second cpu tick");
    cpu_on_main_a: assert property (clk_out.cpu |-> clk_out.main)
        else $error("cpu tick without main tick");
    instr_slot_a: assert property (clk_out.instr_slot |-> clk_out.cpu && clk_out.main)
        else $error("instruction slot off a cpu tick");
    ls_fixed_a: assert property (reg_rd && reg_addr == 16'hffa0 |=> reg_rdata[7:1] == 7'h00)
        else $error("low-speed mode fixed bits not zero");
    hs_fixed_a: assert property (reg_rd && reg_addr == 16'hffa2 |=> reg_rdata[6:0] == 7'h00)
        else $error("high-speed control spare bits not zero");
endmodule

bind sccs_top sccs_properties sccs_properties_i (
    .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .opt_hs_is_x1(opt_hs_is_x1),
    .opt_ls_stoppable(opt_ls_stoppable), .stop_mode(stop_mode), .osc_tick(osc_tick),
    .osc_run(osc_run), .clk_out(clk_out)
);

`default_nettype wire

/* tb/sccs_osc_model.sv */
/*
 * Oscillator model: one-cycle ticks at fixed ratios of ref_clk.
 * Assumes run requests from sccs_top; ref_clk is the only clock.
 */
`timescale 1ns/10ps
`default_nettype none

module sccs_osc_model
    import sccs_pkg::*;
#(
    parameter int X1_DIV  = 3,
    parameter int HSI_DIV = 2,
    parameter int LS_DIV  = 4
)(
    input  wire logic          ref_clk,
    input  wire logic          reset,
    input  wire sccs_osc_run_t osc_run,
    output var sccs_osc_tick_t osc_tick
);
    // ------------------------------------------------------------
    // Tick counters
    // ------------------------------------------------------------
    logic [3:0] x1_cnt_r;
    logic [3:0] hsi_cnt_r;
    logic [3:0] ls_cnt_r;
    wire logic  x1_wrap  = x1_cnt_r == 4'(X1_DIV - 1);
    wire logic  hsi_wrap = hsi_cnt_r == 4'(HSI_DIV - 1);
    wire logic  ls_wrap  = ls_cnt_r == 4'(LS_DIV - 1);

    // Stopped oscillator sends nothing, restarts from phase zero
    always_ff @(posedge ref_clk) begin
        x1_cnt_r  <= (reset || !osc_run.x1_run || x1_wrap) ? 4'h0 : x1_cnt_r + 4'h1;
        hsi_cnt_r <= (reset || !osc_run.hs_int_run || hsi_wrap) ? 4'h0 : hsi_cnt_r + 4'h1;
        ls_cnt_r  <= (reset || !osc_run.ls_run || ls_wrap) ? 4'h0 : ls_cnt_r + 4'h1;
        osc_tick  <= reset ? 3'h0 : {osc_run.x1_run && x1_wrap, osc_run.hs_int_run && hsi_wrap,
                                      osc_run.ls_run && ls_wrap};
    end
endmodule

`default_nettype wire

/* tb/testbench.sv */
/*
 * Self-checking bench of sccs_top with the oscillator model.
 * Assumes package, design, model and checker are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

module testbench
    import sccs_pkg::*;
;
    logic           ref_clk = 1'b0;
    logic           reset = 1'b1;
    logic [15:0]    reg_addr = 16'h0000;
    logic [7:0]     reg_wdata = 8'h00;
    logic           reg_wr = 1'b0;
    logic           reg_rd = 1'b0;
    logic           opt_hs_is_x1 = 1'b1;
    logic           opt_ls_stoppable = 1'b1;
    logic           stop_mode = 1'b0;
    logic [7:0]     reg_rdata;
    sccs_osc_tick_t osc_tick;
    sccs_osc_run_t  osc_run;
    sccs_clk_out_t  clk_out;
    int             bad_count = 0;
    int             compares = 0;
    logic [7:0]     d;
    int             n;

    always #5 ref_clk = ~ref_clk;

    sccs_top sccs_top_i (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .opt_hs_is_x1(opt_hs_is_x1),
        .opt_ls_stoppable(opt_ls_stoppable), .stop_mode(stop_mode), .osc_tick(osc_tick),
        .osc_run(osc_run), .clk_out(clk_out));
    sccs_osc_model sccs_osc_model_i (.ref_clk(ref_clk), .reset(reset), .osc_run(osc_run), .osc_tick(osc_tick));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic stuck();
        bad_count++;
        $display("BAD wait expected done seen timeout");
        results();
    endtask

    // Ends at a falling edge so register effects have landed
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        @(negedge ref_clk);
    endtask

    task automatic rdchk(input string what, input logic [15:0] a, input logic [7:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        d = reg_rdata;
        if (what != "") chk(what, d, exp);
    endtask

    task automatic wait_stat(input logic s);
        int i;
        for (i = 0; i < 40; i++) begin
            rdchk("", 16'hffa1, 8'h00);
            if (d[1] === s) break;
        end
        if (i == 40) stuck();
    endtask

    // Counts ticks from one edge tick to the next: cpu over main, or timer over low-speed
    task automatic gap(input bit w, output int cnt);
        int i;
        bit go;
        logic [1:0] s;
        go = 1'b0;
        cnt = 0;
        for (i = 0; i < 1200; i++) begin
            @(negedge ref_clk);
            s = w ? {clk_out.tmr8, osc_tick.ls} : {clk_out.cpu, clk_out.main};
            if (go) cnt += int'(s[0] === 1'b1);
            if (s[1] === 1'b1 && go) break;
            if (s[1] === 1'b1) go = 1'b1;
        end
        if (i == 1200) stuck();
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rdchk("divider", 16'hfffb, 8'h00);
        rdchk("main mode", 16'hffa1, 8'h00);
        rdchk("hs control", 16'hffa2, 8'h00);
        rdchk("ls mode", 16'hffa0, 8'h00);
        rdchk("unmapped", 16'hffa5, 8'h00);
        chk("osc run", {5'h00, osc_run}, 8'h05);
        $display("test reset done");
    endtask

    task automatic t_fields();
        wr(16'hffa0, 8'hfe);
        rdchk("ls fixed bits", 16'hffa0, 8'h00);
        wr(16'hffa1, 8'hfe);
        rdchk("status read only", 16'hffa1, 8'h00);
        wr(16'hffa2, 8'hff);
        rdchk("hs stop bit", 16'hffa2, 8'h80);
        chk("hs halted", {5'h00, osc_run}, 8'h01);
        wr(16'hffa2, 8'h00);
        chk("hs restarted", {5'h00, osc_run}, 8'h05);
        $display("test fields done");
    endtask

    task automatic t_hs();
        wr(16'hffa1, 8'h01);
        wait_stat(1'b1);
        chk("switch to hs", d, 8'h03);
        for (int c = 0; c < 5; c++) begin
            wr(16'hfffb, 8'(c));
            gap(1'b0, n);
            gap(1'b0, n);
            chk("hs cpu ratio", 8'(n), 8'(1 << c));
        end
        wr(16'hfffb, 8'h05);
        gap(1'b0, n);
        gap(1'b0, n);
        chk("hs ratio kept", 8'(n), 8'h10);
        wr(16'hffa0, 8'h01);
        chk("ls halted", {7'h00, osc_run.ls_run}, 8'h00);
        wr(16'hffa0, 8'h00);
        chk("ls running", {7'h00, osc_run.ls_run}, 8'h01);
        wr(16'hfffb, 8'h00);
        $display("test high speed done");
    endtask

    task automatic t_ls();
        wr(16'hffa1, 8'h00);
        wait_stat(1'b0);
        chk("switch to ls", d, 8'h00);
        n = 0;
        repeat (64) begin
            @(negedge ref_clk);
            n += int'(clk_out.main !== osc_tick.ls);
        end
        chk("main follows ls", 8'(n), 8'h00);
        wr(16'hfffb, 8'h01);
        gap(1'b0, n);
        gap(1'b0, n);
        chk("ls cpu ratio", 8'(n), 8'h02);
        wr(16'hfffb, 8'h02);
        gap(1'b0, n);
        gap(1'b0, n);
        chk("ls ratio kept", 8'(n), 8'h02);
        gap(1'b1, n);
        chk("timer tick", 8'(n), 8'h80);
        $display("test low speed done");
    endtask

    task automatic t_stop();
        wr(16'hffa2, 8'h80);
        chk("hs stop run", {5'h00, osc_run}, 8'h01);
        wr(16'hffa2, 8'h00);
        @(posedge ref_clk);
        stop_mode <= 1'b1;
        @(negedge ref_clk);
        chk("stop instr", {5'h00, osc_run}, 8'h01);
        @(posedge ref_clk);
        stop_mode <= 1'b0;
        $display("test stop done");
    endtask

    task automatic t_opt();
        @(posedge ref_clk);
        reset <= 1'b1;
        opt_hs_is_x1 <= 1'b0;
        opt_ls_stoppable <= 1'b0;
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (3) @(negedge ref_clk);
        chk("internal hs", {5'h00, osc_run}, 8'h03);
        wr(16'hffa1, 8'h01);
        wait_stat(1'b1);
        wr(16'hffa0, 8'h01);
        chk("ls locked", {7'h00, osc_run.ls_run}, 8'h01);
        $display("test options done");
    endtask

    initial begin
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        t_reset();
        t_fields();
        t_hs();
        t_ls();
        t_stop();
        t_opt();
        results();
    end
endmodule

`default_nettype wire
